/* hw/pmt_pkg.sv */
// Constants, register map and carrier types of the period match timer.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
// What this block does
// R1 - An 8-bit counter and an 8-bit period register are both readable and writable by software.
// R2 - Every reset clears the counter to zero.
// R3 - The counter ticks on the system clock divided by four, then by 1, 4 or 16 by the prescale code 00, 01, 1x.
// R4 - Each match feeds a postscaler dividing by the four-bit field value plus one.
// R5 - Each postscaler output pulse sets a sticky match flag that stays until software clears it.
// R6 - Writing the counter, writing the control register or reset clears the prescaler and postscaler.
// R7 - Writing the control register leaves the counter value unchanged.
// R8 - Control bit 2 runs the timer when set; when clear nothing counts.
// R9 - Equality of counter and period is the event driving the postscaler and the flag.
// R10 - The period match is offered as a PWM time base to the capture/compare units.
// R11 - Control bit 7 reads zero and all control bits reset to zero.
// R12 - On the tick after counter equals period the counter returns to zero, giving period plus one ticks.
package pmt_pkg;
   localparam logic [13:0] PMT_OFS_COUNT = 14'h0000;
   localparam logic [13:0] PMT_OFS_PERIOD = 14'h0004;
   // Control sits at a word index; its byte address is four times that index
   localparam logic [11:0] PMT_IDX_CONTROL = 12'hf76;
   localparam logic [13:0] PMT_OFS_CONTROL = {PMT_IDX_CONTROL, 2'b00};
   localparam logic [13:0] PMT_OFS_STATUS = 14'h0008;
   localparam logic [13:0] PMT_OFS_MASK = 14'h000c;
   localparam logic [7:0] PMT_COUNT_RST = 8'h00;
   localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
   localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
   localparam int PMT_RUN_BIT = 2;
   localparam int PMT_POST_LSB = 3;
   localparam int PMT_PRE_LSB = 0;
   localparam logic [1:0] PMT_BASE_DIV_LAST = 2'h3;
   localparam logic [3:0] PMT_PRE_LAST1 = 4'h0;
   localparam logic [3:0] PMT_PRE_LAST4 = 4'h3;
   localparam logic [3:0] PMT_PRE_LAST16 = 4'hf;
   localparam logic [1:0] PMT_RESP_OKAY = 2'h0;
   localparam logic [1:0] PMT_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] post_divide_select;
      logic count_run;
      logic [1:0] pre_divide_select;
   } pmt_control_type;

   typedef enum logic [1:0] {
      PMT_PRE_DIV1 = 2'b00,
      PMT_PRE_DIV4 = 2'b01,
      PMT_PRE_DIV16 = 2'b10
   } pmt_pre_type;
endpackage

/* hw/pmt_prescaler.sv */
// Prescaler: divides the instruction tick by 1, 4 or 16.
// Assumes tick_in is a one-cycle pulse from the base divider.
`timescale 1ns/100ps
module pmt_prescaler
   import pmt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] select,
   output logic tick_out
);
   logic [3:0] pre_ff;
   logic [3:0] last;

   always_comb
   begin
      if (select == PMT_PRE_DIV1)
      begin
         last = PMT_PRE_LAST1;
      end
      else if (select == PMT_PRE_DIV4)
      begin
         last = PMT_PRE_LAST4;
      end
      else
      begin
         last = PMT_PRE_LAST16; // see R3
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear)
      begin
         pre_ff <= 4'h0; // see R6
      end
      else if (tick_in)
      begin
         pre_ff <= (pre_ff >= last) ? 4'h0 : pre_ff + 4'h1;
      end
   end

   assign tick_out = tick_in && (pre_ff >= last);
endmodule // pmt_prescaler

/* hw/pmt_postscaler.sv */
// Postscaler: passes one of every select+1 match pulses.
// Assumes match_in is a one-cycle pulse.
`timescale 1ns/100ps
module pmt_postscaler
   import pmt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clear,
   input wire logic match_in,
   input wire logic [3:0] select,
   output logic pulse_out
);
   logic [3:0] post_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear)
      begin
         post_ff <= 4'h0; // see R6
      end
      else if (match_in)
      begin
         post_ff <= (post_ff >= select) ? 4'h0 : post_ff + 4'h1; // see R4
      end
   end

   assign pulse_out = match_in && (post_ff >= select);
endmodule // pmt_postscaler

/* hw/pmt_timer.sv */
// Period match timer top: AXI4-Lite slave, counter, match, flag and interrupt.
// Assumes one clock aclk at 100 MHz and synchronous active-low reset.
`timescale 1ns/100ps
module pmt_timer
   import pmt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [13:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [13:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic pwm_time_base,
   output logic irq
);
   logic [7:0] tick_count_ff;
   logic [7:0] period_value_ff;
   pmt_control_type period_timer_control_ff;
   logic period_match_flag_ff;
   logic irq_mask_ff;
   logic [1:0] base_div_ff;
   logic [13:0] awaddr_ff;
   logic awready_ff;
   logic [31:0] wdata_ff;
   logic wready_ff;
   logic [3:0] wstrb_ff;
   logic pwm_time_base_ff;
   logic irq_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic arready_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic base_tick;
   logic pre_tick;
   logic match;
   logic post_pulse;
   logic wr_fire;
   logic wr_count;
   logic wr_period;
   logic wr_control;
   logic wr_status;
   logic wr_mask;
   logic wr_ok;
   logic lane0;
   logic scaler_clear;

   // Write takes place once both address and data are held and no response waits
   assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
   assign lane0 = wstrb_ff[0];
   assign wr_count = wr_fire && lane0 && (awaddr_ff == PMT_OFS_COUNT);
   assign wr_period = wr_fire && lane0 && (awaddr_ff == PMT_OFS_PERIOD);
   assign wr_control = wr_fire && lane0 && (awaddr_ff == PMT_OFS_CONTROL);
   assign wr_status = wr_fire && lane0 && (awaddr_ff == PMT_OFS_STATUS);
   assign wr_mask = wr_fire && lane0 && (awaddr_ff == PMT_OFS_MASK);
   assign scaler_clear = wr_count || wr_control; // see R6

   always_comb
   begin
      if (awaddr_ff == PMT_OFS_COUNT || awaddr_ff == PMT_OFS_PERIOD || awaddr_ff == PMT_OFS_CONTROL
         || awaddr_ff == PMT_OFS_STATUS || awaddr_ff == PMT_OFS_MASK)
      begin
         wr_ok = 1'b1;
      end
      else
      begin
         wr_ok = 1'b0;
      end
   end

   // Write address and data channels, accepted in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b1;
         awaddr_ff <= 14'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         awready_ff <= 1'b0;
         awaddr_ff <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
         awready_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_ff <= 1'b1;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         wready_ff <= 1'b0;
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
         wready_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= PMT_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_ok ? PMT_RESP_OKAY : PMT_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // Read channel: one cycle from address to data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= PMT_RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_ff)
      begin
         rvalid_ff <= 1'b1;
         arready_ff <= 1'b0;
         rresp_ff <= PMT_RESP_OKAY;
         if (s_axi_araddr == PMT_OFS_COUNT)
         begin
            rdata_ff <= {24'h000000, tick_count_ff}; // see R1
         end
         else if (s_axi_araddr == PMT_OFS_PERIOD)
         begin
            rdata_ff <= {24'h000000, period_value_ff}; // see R1
         end
         else if (s_axi_araddr == PMT_OFS_CONTROL)
         begin
            rdata_ff <= {24'h000000, 1'b0, period_timer_control_ff}; // see R11
         end
         else if (s_axi_araddr == PMT_OFS_STATUS)
         begin
            rdata_ff <= {31'h00000000, period_match_flag_ff};
         end
         else if (s_axi_araddr == PMT_OFS_MASK)
         begin
            rdata_ff <= {31'h00000000, irq_mask_ff};
         end
         else
         begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= PMT_RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

   // Control and period registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         period_timer_control_ff <= PMT_CONTROL_RST; // see R11
         period_value_ff <= PMT_PERIOD_RST;
         irq_mask_ff <= 1'b0;
      end
      else
      begin
         if (wr_control)
         begin
            period_timer_control_ff <= wdata_ff[6:0];
         end
         if (wr_period)
         begin
            period_value_ff <= wdata_ff[7:0]; // see R1
         end
         if (wr_mask)
         begin
            irq_mask_ff <= wdata_ff[0];
         end
      end
   end

   // Instruction tick: system clock divided by four, cleared to zero while stopped
   always_ff @(posedge aclk)
   begin
      if (!aresetn || scaler_clear || !period_timer_control_ff.count_run)
      begin
         base_div_ff <= 2'h0; // see R8
      end
      else
      begin
         base_div_ff <= base_div_ff + 2'h1;
      end
   end

   assign base_tick = period_timer_control_ff.count_run && (base_div_ff == PMT_BASE_DIV_LAST); // see R3

   pmt_prescaler pmt_prescaler_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(scaler_clear),
      .tick_in(base_tick),
      .select(period_timer_control_ff.pre_divide_select),
      .tick_out(pre_tick)
   );

   assign match = pre_tick && (tick_count_ff == period_value_ff); // see R9

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_count_ff <= PMT_COUNT_RST; // see R2
      end
      else if (wr_count)
      begin
         tick_count_ff <= wdata_ff[7:0]; // see R1
      end
      else if (match)
      begin
         tick_count_ff <= 8'h00; // see R12
      end
      else if (pre_tick)
      begin
         tick_count_ff <= tick_count_ff + 8'h01; // see R7
      end
   end

   pmt_postscaler pmt_postscaler_i (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(scaler_clear),
      .match_in(match),
      .select(period_timer_control_ff.post_divide_select),
      .pulse_out(post_pulse)
   );

   // Sticky flag: hardware set wins over a write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         period_match_flag_ff <= 1'b0;
      end
      else if (post_pulse)
      begin
         period_match_flag_ff <= 1'b1; // see R5
      end
      else if (wr_status && wdata_ff[0])
      begin
         period_match_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pwm_time_base_ff <= 1'b0;
         irq_ff <= 1'b0;
      end
      else
      begin
         pwm_time_base_ff <= match; // see R10
         irq_ff <= (period_match_flag_ff || post_pulse) && irq_mask_ff;
      end
   end

   assign pwm_time_base = pwm_time_base_ff;
   assign irq = irq_ff;

   property p_count_reset;
      @(posedge aclk) !aresetn |=> tick_count_ff == 8'h00;
   endproperty
   a_count_reset: assert property (p_count_reset) else $error("counter not cleared by reset"); // see R2

   property p_wrap;
      @(posedge aclk) disable iff (!aresetn) (match && !wr_count) |=> tick_count_ff == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap on match"); // see R12

   property p_ctrl_keeps_count;
      @(posedge aclk) disable iff (!aresetn) (wr_control && !pre_tick) |=> $stable(tick_count_ff);
   endproperty
   a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) else $error("control write moved counter"); // see R7

   property p_stopped;
      @(posedge aclk) disable iff (!aresetn) !period_timer_control_ff.count_run && !wr_count |=> $stable(tick_count_ff);
   endproperty
   a_stopped: assert property (p_stopped) else $error("tick while stopped"); // see R8

   sequence s_flag_set;
      post_pulse;
   endsequence
   property p_flag;
      @(posedge aclk) disable iff (!aresetn) s_flag_set |=> period_match_flag_ff;
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set by postscaler"); // see R5

   property p_match_eq;
      @(posedge aclk) disable iff (!aresetn) match |-> tick_count_ff == period_value_ff;
   endproperty
   a_match_eq: assert property (p_match_eq) else $error("match without equality"); // see R9

   property p_pwm;
      @(posedge aclk) disable iff (!aresetn) match |=> pwm_time_base;
   endproperty
   a_pwm: assert property (p_pwm) else $error("time base not driven"); // see R10

   property p_post11;
      @(posedge aclk) disable iff (!aresetn)
         (period_timer_control_ff.post_divide_select == 4'h0) && match |-> post_pulse;
   endproperty
   a_post11: assert property (p_post11) else $error("1:1 postscale lost a pulse"); // see R4

   property p_bit7;
      @(posedge aclk) disable iff (!aresetn) rvalid_ff && $past(s_axi_araddr) == PMT_OFS_CONTROL && $rose(rvalid_ff)
         |-> rdata_ff[7] == 1'b0;
   endproperty
   a_bit7: assert property (p_bit7) else $error("control bit 7 not zero"); // see R11

   property p_base;
      @(posedge aclk) disable iff (!aresetn) base_tick |=> !base_tick [*3];
   endproperty
   a_base: assert property (p_base) else $error("base tick faster than divide by four"); // see R3
endmodule // pmt_timer

/* verif/pmt_timer_bench.sv */
// Self-checking bench for the period match timer: register access, match timing, postscaler and interrupt.
// Assumes the design files under hw/, one 100 MHz clock and an AXI4-Lite master driven from here.
`timescale 1ns/100ps
module pmt_timer_bench;
   import pmt_pkg::*;
   logic aclk, aresetn;
   logic [13:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, pwm, irq;
   logic [1:0] bresp, rresp, rs;
   int fail_count, checked, n, p;
   logic [7:0] v;
   logic [13:0] reg_addr [5] = '{PMT_OFS_COUNT, PMT_OFS_PERIOD, PMT_OFS_CONTROL, PMT_OFS_STATUS, PMT_OFS_MASK};
   logic [7:0] reg_rst [5] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

   pmt_timer pmt_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pwm_time_base(pwm), .irq(irq));

   function automatic int pre_div(input logic [1:0] s);
      return (s == 2'b00) ? 1 : ((s == 2'b01) ? 4 : 16);
   endfunction

   function automatic logic [7:0] ctl(input logic [3:0] post, input logic run, input logic [1:0] pre);
      return {1'b0, post, run, pre};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_wr(input logic [13:0] a, input logic [7:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         k++;
      end
      while (bvalid !== 1'b1 && k < 200);
      r = bresp;
      bready <= 1'b0;
      chk("write answer", 32'h1, {31'h0, k < 200});
   endtask

   task automatic axi_rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         k++;
      end
      while (rvalid !== 1'b1 && k < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk("read answer", 32'h1, {31'h0, k < 200});
   endtask

   task automatic wr(input logic [13:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("write response", 32'(PMT_RESP_OKAY), 32'(r));
   endtask

   task automatic rd_chk(input string what, input logic [13:0] a, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(what, {24'h0, exp}, d);
      chk("read response", 32'(PMT_RESP_OKAY), 32'(r));
   endtask

   // Cycles until the next match pulse, bounded
   task automatic wait_pulse(output int c);
      c = 0;
      do
      begin
         @(posedge aclk);
         c++;
      end
      while (pwm !== 1'b1 && c < 5000);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial
   begin
      repeat (60000) @(posedge aclk);
      fail_count++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial
   begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      fail_count = 0;
      checked = 0;
      void'($urandom(32'he3551bb4));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rd_chk("reset value", reg_addr[i], reg_rst[i]);
      $display("test reset values done");
      v = 8'($urandom);
      wr(PMT_OFS_COUNT, v);
      rd_chk("count", PMT_OFS_COUNT, v);
      p = $urandom_range(0, 255);
      wr(PMT_OFS_PERIOD, 8'(p));
      rd_chk("period", PMT_OFS_PERIOD, 8'(p));
      wr(PMT_OFS_CONTROL, 8'hfb);
      rd_chk("control", PMT_OFS_CONTROL, 8'h7b);
      wr(PMT_OFS_CONTROL, ctl(4'($urandom), 1'b0, 2'($urandom)));
      rd_chk("count after control write", PMT_OFS_COUNT, v);
      repeat (100) @(posedge aclk);
      rd_chk("count while stopped", PMT_OFS_COUNT, v);
      axi_rd(14'h0010, rd, rs);
      chk("unmapped read response", 32'(PMT_RESP_SLVERR), 32'(rs));
      chk("unmapped read data", 32'h0, rd);
      axi_wr(14'h0010, 8'h5a, rs);
      chk("unmapped write response", 32'(PMT_RESP_SLVERR), 32'(rs));
      $display("test register access done");
      for (int s = 0; s < 4; s++)
      begin
         p = (s == 0) ? 0 : $urandom_range(1, 15);
         wr(PMT_OFS_CONTROL, 8'h00);
         wr(PMT_OFS_PERIOD, 8'(p));
         wr(PMT_OFS_COUNT, 8'h00);
         wr(PMT_OFS_CONTROL, ctl(4'h0, 1'b1, 2'(s)));
         wait_pulse(n);
         wait_pulse(n);
         chk("match spacing", 32'((p + 1) * 4 * pre_div(2'(s))), 32'(n));
      end
      $display("test prescale and period done");
      for (int k = 0; k < 16; k++)
      begin
         wr(PMT_OFS_CONTROL, 8'h00);
         wr(PMT_OFS_STATUS, 8'h01);
         wr(PMT_OFS_MASK, 8'h01);
         wr(PMT_OFS_COUNT, 8'h00);
         wr(PMT_OFS_PERIOD, 8'h03);
         wr(PMT_OFS_CONTROL, ctl(4'(k), 1'b1, 2'b00));
         if (k == 1)
         begin
            wait_pulse(n);
            wr(PMT_OFS_COUNT, 8'h00);
         end
         n = 0;
         p = 0;
         while (irq !== 1'b1 && p < 3000)
         begin
            @(posedge aclk);
            if (pwm === 1'b1)
               n++;
            p++;
         end
         chk("matches per interrupt", 32'(k + 1), 32'(n));
         rd_chk("flag latched", PMT_OFS_STATUS, 8'h01);
         wr(PMT_OFS_MASK, 8'h00);
         repeat (3) @(posedge aclk);
         chk("masked interrupt", 32'h0, {31'h0, irq});
         wr(PMT_OFS_CONTROL, 8'h00);
         wr(PMT_OFS_STATUS, 8'h01);
         rd_chk("flag cleared", PMT_OFS_STATUS, 8'h00);
      end
      $display("test postscaler and interrupt done");
      tally_and_finish();
   end
endmodule // pmt_timer_bench
